// ==== hw/sps_pkg.sv ====
// ****************************************************************
// Shared constants for the slot power sequencer.
// ****************************************************************
package sps_pkg;

  // Register offsets.
  localparam logic [3:0] OFS_STATUS = 4'h0; // Sticky fault events, write one to clear.
  localparam logic [3:0] OFS_MASK   = 4'h4; // Interrupt mask.
  localparam logic [3:0] OFS_CTRL   = 4'h8; // Bus-mode enable levels.
  localparam logic [3:0] OFS_STATE  = 4'hC; // Live slot state, read only.

  // Field positions shared by STATUS, MASK and CTRL.
  localparam int BIT_MAIN_A = 0;
  localparam int BIT_AUX_A  = 1;
  localparam int BIT_MAIN_B = 2;
  localparam int BIT_AUX_B  = 3;
  localparam int EVT_W      = 4;

  // Bits of STATE per slot, slot b above a.
  localparam int SLOT_STATE_W = 8;

  // Reset values.
  localparam logic [EVT_W-1:0] RST_EVT = 4'h0;

  // Breaker filter time; the real figure is set by an outside capacitor.
  localparam int BREAKER_FILTER_TIME_NS = 1000000;
  localparam int CLK_PERIOD_NS          = 100;
  // A least time, so round up to whole cycles.
  localparam int FILTER_CYCLES = (BREAKER_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Main output state of one slot.
  typedef enum logic {MAIN_OFF, MAIN_ON} sps_main_t;

endpackage

// ==== hw/sps_slot.sv ====
`timescale 1ns/100ps
// ****************************************************************
// One slot: enable edges, breaker filter, fault latches, gate modes.
// ****************************************************************
module sps_slot #(
  parameter int CNT_W   = 16,
  parameter int FILT_CY = sps_pkg::FILTER_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic main_enable,   // Main enable pin.
  input  wire logic aux_enable,    // Aux enable pin.
  input  wire logic bus_main,      // Bus-mode main enable level.
  input  wire logic bus_aux,       // Bus-mode aux enable level.
  input  wire logic rail5_limit,   // 5V sense at its limit.
  input  wire logic rail3_limit,   // 3.3V sense at its limit.
  input  wire logic hard_fault,    // Overcurrent, thermal or undervoltage.
  input  wire logic aux_fault,     // Aux current limit or short.
  input  wire logic rail5_good_mon,
  input  wire logic rail3_good_mon,
  input  wire logic stby_ok,       // Standby above its lockout.
  output logic      rail5_charge_q,
  output logic      rail3_charge_q,
  output logic      rail5_reg_q,
  output logic      rail3_reg_q,
  output logic      pull_low_q,
  output logic      discharge_q,
  output logic      aux_out_q,
  output logic      pg5_q,
  output logic      pg3_q,
  output logic      main_flt_q,
  output logic      aux_flt_q,
  output logic      main_evt_q,    // One-cycle pulse on a new main fault.
  output logic      aux_evt_q      // One-cycle pulse on a new aux fault.
);

  // ****************************************************************
  // Enable synchronisers and edge detection.
  // ****************************************************************
  logic [1:0] s1_q;                // First stage, read only by the second.
  logic [1:0] s2_q;                // Second stage.
  logic [1:0] prev_q;              // Resolved enables one cycle ago.
  logic       main_lvl;
  logic       aux_lvl;

  // Pins are low in bus mode, so an OR lets either source drive the slot.
  assign main_lvl = s2_q[0] | bus_main;
  assign aux_lvl  = s2_q[1] | bus_aux;

  wire main_rise = main_lvl & ~prev_q[0];
  wire main_fall = ~main_lvl & prev_q[0];
  wire aux_rise  = aux_lvl & ~prev_q[1];
  wire aux_fall  = ~aux_lvl & prev_q[1];

  // Two flops per pin against metastability.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q   <= 2'h0;
      s2_q   <= 2'h0;
      prev_q <= 2'h0;
    end
    else
    begin
      s1_q   <= {aux_enable, main_enable};
      s2_q   <= s1_q;
      prev_q <= {aux_lvl, main_lvl};
    end
  end

  // ****************************************************************
  // Breaker filter and main output control.
  // ****************************************************************
  sps_pkg::sps_main_t main_q;
  sps_pkg::sps_main_t main_d;
  logic [CNT_W-1:0]   cnt_q;
  logic [CNT_W-1:0]   cnt_d;
  logic               in_limit;
  logic               trip;
  logic               main_kill;

  assign in_limit  = (main_q == sps_pkg::MAIN_ON) & (rail5_limit | rail3_limit);
  assign trip      = in_limit & (cnt_q == CNT_W'(FILT_CY - 1));
  assign main_kill = trip | hard_fault;

  // Count only while the limit lasts; dropping out of limit starts over.
  always_comb
  begin
    cnt_d = in_limit ? cnt_q + CNT_W'(1) : '0;
    if (trip)
      cnt_d = '0;
  end

  // A faulted slot refuses a new turn-on until the latch is cleared.
  always_comb
  begin
    main_d = main_q;
    unique case (main_q)
      sps_pkg::MAIN_OFF:
        if (main_rise & ~main_flt_q & ~hard_fault)
          main_d = sps_pkg::MAIN_ON;
      sps_pkg::MAIN_ON:
        if (main_fall | main_kill)
          main_d = sps_pkg::MAIN_OFF;
    endcase
  end

  wire main_set  = (main_q == sps_pkg::MAIN_ON) & main_kill;
  wire aux_set   = aux_out_q & aux_fault;
  wire aux_on_d  = aux_out_q ? ~(aux_fall | aux_fault | ~stby_ok)
                             : aux_rise & stby_ok & ~aux_flt_q;

  // ****************************************************************
  // State, latches and registered outputs.
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      main_q     <= sps_pkg::MAIN_OFF;
      cnt_q      <= '0;
      main_flt_q <= 1'b0;
      aux_flt_q  <= 1'b0;
      aux_out_q  <= 1'b0;
      main_evt_q <= 1'b0;
      aux_evt_q  <= 1'b0;
    end
    else
    begin
      main_q     <= main_d;
      cnt_q      <= cnt_d;
      // Set wins over a clear in the same cycle.
      main_flt_q <= main_set | (main_flt_q & main_lvl);
      aux_flt_q  <= aux_set | (aux_flt_q & aux_lvl);
      aux_out_q  <= aux_on_d;
      main_evt_q <= main_set;
      aux_evt_q  <= aux_set;
    end
  end

  // Gate modes follow the next main state so a kill lands in one cycle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rail5_charge_q <= 1'b0;
      rail3_charge_q <= 1'b0;
      rail5_reg_q    <= 1'b0;
      rail3_reg_q    <= 1'b0;
      pull_low_q     <= 1'b0;
      discharge_q    <= 1'b1;
      pg5_q          <= 1'b0;
      pg3_q          <= 1'b0;
    end
    else
    begin
      rail5_charge_q <= (main_d == sps_pkg::MAIN_ON) & ~rail5_limit;
      rail3_charge_q <= (main_d == sps_pkg::MAIN_ON) & ~rail3_limit;
      rail5_reg_q    <= (main_d == sps_pkg::MAIN_ON) & rail5_limit;
      rail3_reg_q    <= (main_d == sps_pkg::MAIN_ON) & rail3_limit;
      pull_low_q     <= main_kill | (pull_low_q & main_d == sps_pkg::MAIN_OFF);
      discharge_q    <= (main_d == sps_pkg::MAIN_OFF) & ~main_kill & ~pull_low_q;
      pg5_q          <= (main_d == sps_pkg::MAIN_ON) & rail5_good_mon;
      pg3_q          <= (main_d == sps_pkg::MAIN_ON) & rail3_good_mon;
    end
  end

endmodule // sps_slot

// ==== hw/sps_top.sv ====
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
// ****************************************************************
// Two-slot hot-plug power sequencer with fault latches and interrupt.
// ****************************************************************
// Contract
// - Aux output turns on only on rising edge.
// - Aux enable low clears aux fault latch.
// - Main enable edge switches its slot's two mains on, off.
// - Main enable low clears main fault latch.
// - Regulate at limit, trip after filter time.
// - Hard faults pull affected slot's gates low.
// - Gates charge on power-up, discharge on power-down.
// - Aux stays off until standby clears lockout.
// - Power-good from rail monitor inputs.
// - Aux overcurrent or short is an aux fault.
// - Both latches set need both enables low.
// - Fault raises interrupt, write one clears it.
module sps_top #(
  parameter int CNT_W   = 16,
  parameter int FILT_CY = sps_pkg::FILTER_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port.
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Standby supply above its lockout threshold.
  input  wire logic        standby_supply_ok,
  // Slot a pins.
  input  wire logic        main_enable_a,
  input  wire logic        aux_enable_a,
  input  wire logic        rail5_current_sense_a,
  input  wire logic        rail3_current_sense_a,
  input  wire logic        overcurrent_a,
  input  wire logic        thermal_shutdown_a,
  input  wire logic        undervoltage_lockout_a,
  input  wire logic        aux_overcurrent_a,
  input  wire logic        rail5_good_monitor_a,
  input  wire logic        rail3_good_monitor_a,
  output logic             rail5_gate_a,
  output logic             rail3_gate_a,
  output logic             rail5_gate_reg_a,
  output logic             rail3_gate_reg_a,
  output logic             gate_pull_low_a,
  output logic             gate_discharge_a,
  output logic             standby_slot_out_a,
  output logic             power_good5_a,
  output logic             power_good3_a,
  input  wire logic        slot_fault_n_a_i,
  output logic             slot_fault_n_a_o,
  output logic             slot_fault_n_a_oe,
  // Slot b pins.
  input  wire logic        main_enable_b,
  input  wire logic        aux_enable_b,
  input  wire logic        rail5_current_sense_b,
  input  wire logic        rail3_current_sense_b,
  input  wire logic        overcurrent_b,
  input  wire logic        thermal_shutdown_b,
  input  wire logic        undervoltage_lockout_b,
  input  wire logic        aux_overcurrent_b,
  input  wire logic        rail5_good_monitor_b,
  input  wire logic        rail3_good_monitor_b,
  output logic             rail5_gate_b,
  output logic             rail3_gate_b,
  output logic             rail5_gate_reg_b,
  output logic             rail3_gate_reg_b,
  output logic             gate_pull_low_b,
  output logic             gate_discharge_b,
  output logic             standby_slot_out_b,
  output logic             power_good5_b,
  output logic             power_good3_b,
  input  wire logic        slot_fault_n_b_i,
  output logic             slot_fault_n_b_o,
  output logic             slot_fault_n_b_oe,
  // Open-drain interrupt.
  input  wire logic        int_n_i,
  output logic             int_n_o,
  output logic             int_n_oe
);

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  logic [sps_pkg::EVT_W-1:0] status_q;  // Sticky fault events.
  logic [sps_pkg::EVT_W-1:0] status_d;
  logic [sps_pkg::EVT_W-1:0] mask_q;    // Interrupt mask.
  logic [sps_pkg::EVT_W-1:0] ctrl_q;    // Bus-mode enable levels.
  logic [sps_pkg::EVT_W-1:0] evt;       // Fault event pulses.
  logic                      main_flt_a;
  logic                      aux_flt_a;
  logic                      main_flt_b;
  logic                      aux_flt_b;
  logic                      evt_main_a;
  logic                      evt_aux_a;
  logic                      evt_main_b;
  logic                      evt_aux_b;

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  wire hit_status = reg_addr == sps_pkg::OFS_STATUS;
  wire hit_mask   = reg_addr == sps_pkg::OFS_MASK;
  wire hit_ctrl   = reg_addr == sps_pkg::OFS_CTRL;
  wire hit_state  = reg_addr == sps_pkg::OFS_STATE;
  wire wr_status  = reg_wr & hit_status;
  wire wr_mask    = reg_wr & hit_mask;
  wire wr_ctrl    = reg_wr & hit_ctrl;

  wire [sps_pkg::EVT_W-1:0] wr_evt = reg_wdata[sps_pkg::EVT_W-1:0];

  // ****************************************************************
  // Slot instances.
  // ****************************************************************
  // Hard faults share one kill path; the other slot never sees them.
  wire hard_a = overcurrent_a | thermal_shutdown_a | undervoltage_lockout_a;
  wire hard_b = overcurrent_b | thermal_shutdown_b | undervoltage_lockout_b;

  sps_slot #(
    .CNT_W   (CNT_W),
    .FILT_CY (FILT_CY)
  ) u_slot_a (
    .clk            (clk),
    .rst            (rst),
    .main_enable    (main_enable_a),
    .aux_enable     (aux_enable_a),
    .bus_main       (ctrl_q[sps_pkg::BIT_MAIN_A]),
    .bus_aux        (ctrl_q[sps_pkg::BIT_AUX_A]),
    .rail5_limit    (rail5_current_sense_a),
    .rail3_limit    (rail3_current_sense_a),
    .hard_fault     (hard_a),
    .aux_fault      (aux_overcurrent_a),
    .rail5_good_mon (rail5_good_monitor_a),
    .rail3_good_mon (rail3_good_monitor_a),
    .stby_ok        (standby_supply_ok),
    .rail5_charge_q (rail5_gate_a),
    .rail3_charge_q (rail3_gate_a),
    .rail5_reg_q    (rail5_gate_reg_a),
    .rail3_reg_q    (rail3_gate_reg_a),
    .pull_low_q     (gate_pull_low_a),
    .discharge_q    (gate_discharge_a),
    .aux_out_q      (standby_slot_out_a),
    .pg5_q          (power_good5_a),
    .pg3_q          (power_good3_a),
    .main_flt_q     (main_flt_a),
    .aux_flt_q      (aux_flt_a),
    .main_evt_q     (evt_main_a),
    .aux_evt_q      (evt_aux_a)
  );

  sps_slot #(
    .CNT_W   (CNT_W),
    .FILT_CY (FILT_CY)
  ) u_slot_b (
    .clk            (clk),
    .rst            (rst),
    .main_enable    (main_enable_b),
    .aux_enable     (aux_enable_b),
    .bus_main       (ctrl_q[sps_pkg::BIT_MAIN_B]),
    .bus_aux        (ctrl_q[sps_pkg::BIT_AUX_B]),
    .rail5_limit    (rail5_current_sense_b),
    .rail3_limit    (rail3_current_sense_b),
    .hard_fault     (hard_b),
    .aux_fault      (aux_overcurrent_b),
    .rail5_good_mon (rail5_good_monitor_b),
    .rail3_good_mon (rail3_good_monitor_b),
    .stby_ok        (standby_supply_ok),
    .rail5_charge_q (rail5_gate_b),
    .rail3_charge_q (rail3_gate_b),
    .rail5_reg_q    (rail5_gate_reg_b),
    .rail3_reg_q    (rail3_gate_reg_b),
    .pull_low_q     (gate_pull_low_b),
    .discharge_q    (gate_discharge_b),
    .aux_out_q      (standby_slot_out_b),
    .pg5_q          (power_good5_b),
    .pg3_q          (power_good3_b),
    .main_flt_q     (main_flt_b),
    .aux_flt_q      (aux_flt_b),
    .main_evt_q     (evt_main_b),
    .aux_evt_q      (evt_aux_b)
  );

  assign evt = {evt_aux_b, evt_main_b, evt_aux_a, evt_main_a};

  // ****************************************************************
  // Sticky status with write-one-to-clear.
  // ****************************************************************
  // A new event in the clearing cycle survives the clear.
  assign status_d = (status_q & ~(wr_status ? wr_evt : sps_pkg::RST_EVT)) | evt;

  // Register updates.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status_q <= sps_pkg::RST_EVT;
      mask_q   <= sps_pkg::RST_EVT;
      ctrl_q   <= sps_pkg::RST_EVT;
    end
    else
    begin
      status_q <= status_d;
      if (wr_mask)
        mask_q <= wr_evt;
      if (wr_ctrl)
        ctrl_q <= wr_evt;
    end
  end

  // ****************************************************************
  // Read data.
  // ****************************************************************
  // Live slot state.
  wire [sps_pkg::SLOT_STATE_W-1:0] state_a = {slot_fault_n_a_i, power_good5_a, power_good3_a,
                                             standby_slot_out_a, rail5_gate_a | rail5_gate_reg_a,
                                             gate_pull_low_a, aux_flt_a, main_flt_a};
  wire [sps_pkg::SLOT_STATE_W-1:0] state_b = {slot_fault_n_b_i, power_good5_b, power_good3_b,
                                             standby_slot_out_b, rail5_gate_b | rail5_gate_reg_b,
                                             gate_pull_low_b, aux_flt_b, main_flt_b};

  logic [31:0] rd_mux;

  // Unmapped offsets read as zero.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_status)
      rd_mux = {28'h000_0000, status_q};
    else if (hit_mask)
      rd_mux = {28'h000_0000, mask_q};
    else if (hit_ctrl)
      rd_mux = {28'h000_0000, ctrl_q};
    else if (hit_state)
      rd_mux = {15'h0000, int_n_i, state_b, state_a};
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  // ****************************************************************
  // Open-drain outputs.
  // ****************************************************************
  // Pins are only pulled low, so data stays zero.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      int_n_o           <= 1'b0;
      int_n_oe          <= 1'b0;
      slot_fault_n_a_o  <= 1'b0;
      slot_fault_n_a_oe <= 1'b0;
      slot_fault_n_b_o  <= 1'b0;
      slot_fault_n_b_oe <= 1'b0;
    end
    else
    begin
      int_n_o           <= 1'b0;
      int_n_oe          <= |(status_d & mask_q);
      slot_fault_n_a_o  <= 1'b0;
      slot_fault_n_a_oe <= main_flt_a | aux_flt_a;
      slot_fault_n_b_o  <= 1'b0;
      slot_fault_n_b_oe <= main_flt_b | aux_flt_b;
    end
  end

endmodule // sps_top

// ==== verification/sps_top_checker.sv ====
`timescale 1ns/100ps
// ****
// Checks on slot a.
// ****
module sps_top_checker #(
  parameter int CNT_W   = 16,
  parameter int FILT_CY = 8
) (
  input wire logic clk, rst, main_enable_a, aux_enable_a, standby_supply_ok,
  input wire logic rail5_current_sense_a, rail3_current_sense_a, overcurrent_a,
  input wire logic thermal_shutdown_a, undervoltage_lockout_a, aux_overcurrent_a,
  input wire logic rail5_good_monitor_a, rail5_gate_a, rail3_gate_a, rail5_gate_reg_a,
  input wire logic rail3_gate_reg_a, gate_pull_low_a, gate_discharge_a, standby_slot_out_a,
  input wire logic power_good5_a, slot_fault_n_a_oe
);
  wire hard_a = overcurrent_a | thermal_shutdown_a | undervoltage_lockout_a; // Any hard fault.
  wire on_a = rail5_gate_a | rail3_gate_a | rail5_gate_reg_a | rail3_gate_reg_a; // Mains driven.
  wire lim_a = rail5_current_sense_a | rail3_current_sense_a; // A rail is limiting.
  logic [CNT_W-1:0] lim_q; // Cycles spent limiting while on.
  // Mirrors the breaker filter.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst) lim_q <= '0;
    else lim_q <= (lim_a && on_a) ? lim_q + 1'b1 : '0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Pins low, no fault, past the synchroniser.
  sequence quiet_s;
    (!main_enable_a && !aux_enable_a && !aux_overcurrent_a && !hard_a) [*6];
  endsequence
  // Pin rose three edges back.
  sequence main_rise_s;
    $past(main_enable_a, 3) && !$past(main_enable_a, 4);
  endsequence
  hard_pull_a: assert property (hard_a && on_a |=> gate_pull_low_a && !on_a)
    else $error("hard fault left gate driven");
  main_edge_a: assert property ($fell(gate_discharge_a) |-> main_rise_s)
    else $error("mains on without pin edge");
  aux_edge_a: assert property ($rose(standby_slot_out_a) |-> $past(aux_enable_a, 3) &&
    !$past(aux_enable_a, 4) && $past(standby_supply_ok)) else $error("aux on without edge");
  discharge_off_a: assert property (gate_discharge_a |-> !(rail5_gate_a | rail3_gate_a | gate_pull_low_a))
    else $error("discharge while driven");
  limit_reg_a: assert property (rail5_current_sense_a && rail5_gate_a |=> rail5_gate_reg_a || gate_pull_low_a)
    else $error("no regulation at limit");
  trip_bound_a: assert property (lim_q <= FILT_CY + 2)
    else $error("breaker did not trip");
  aux_trip_a: assert property (standby_slot_out_a && aux_overcurrent_a |-> ##[1:2] !standby_slot_out_a)
    else $error("aux stayed on after fault");
  pg_follow_a: assert property (!rail5_good_monitor_a |=> !power_good5_a)
    else $error("power good without monitor");
  fault_release_a: assert property (quiet_s |-> !slot_fault_n_a_oe)
    else $error("fault pin held after release");
endmodule // sps_top_checker
bind sps_top sps_top_checker #(.CNT_W(CNT_W), .FILT_CY(FILT_CY)) chk_u (.clk, .rst, .main_enable_a,
  .aux_enable_a, .standby_supply_ok, .rail5_current_sense_a, .rail3_current_sense_a, .overcurrent_a,
  .thermal_shutdown_a, .undervoltage_lockout_a, .aux_overcurrent_a, .rail5_good_monitor_a, .rail5_gate_a,
  .rail3_gate_a, .rail5_gate_reg_a, .rail3_gate_reg_a, .gate_pull_low_a, .gate_discharge_a,
  .standby_slot_out_a, .power_good5_a, .slot_fault_n_a_oe);

// ==== verification/sps_host.sv ====
`timescale 1ns/100ps
// ****
// Host controller that drives the slot enable pins.
// ****
module sps_host (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] want_main, // Wanted main level per slot.
  input  wire logic [1:0] want_aux,  // Wanted aux level per slot.
  input  wire logic       bus_mode,  // Power is switched over the register port.
  input  wire logic [2:0] lag,       // Extra cycles before the pins follow.
  output logic      [1:0] main_en,
  output logic      [1:0] aux_en
);
  logic [3:0] pipe_q [8]; // Wanted levels, one stage a cycle.
  // Pins trail the request by lag plus one cycles.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      for (int i = 0; i < 8; i++) pipe_q[i] <= 4'h0;
    else
    begin
      pipe_q[0] <= {want_main, want_aux};
      for (int i = 1; i < 8; i++) pipe_q[i] <= pipe_q[i-1];
    end
  end
  // In bus mode every pin is held low.
  assign {main_en, aux_en} = bus_mode ? 4'h0 : pipe_q[lag];
endmodule // sps_host

// ==== verification/sps_top_tb.sv ====
`timescale 1ns/100ps
// ****
// Self-checking bench.
// ****
module sps_top_tb;
  localparam int FT = 8; // Short filter.
  localparam logic [3:0] ST = sps_pkg::OFS_STATUS, MK = sps_pkg::OFS_MASK, CT = sps_pkg::OFS_CTRL;
  localparam logic [3:0] SA = sps_pkg::OFS_STATE; // Offsets.
  typedef struct packed {logic [31:0] v; logic [31:0] m;} sps_note_t; // Expected read and care mask.
  logic clk, rst, reg_wr, reg_rd, stby, bus_mode, rd_seen, int_oe;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0] wm, wa, s5, s3, oc, th, uv, ax, g5, g3; // Host wants and slot stimulus.
  logic [1:0] me, ae, g5o, g3o, r5o, r3o, pl, dis, axo, p5, p3, foe; // Pins per slot.
  logic [2:0] lag;
  logic [16:0] lf_q;
  int compares, miscompares, n, s;
  sps_note_t notes[$];
  sps_note_t nt;
  wire [1:0] flv = ~foe; // Open-drain pins are pulled up.
  wire int_lv = ~int_oe;
  sps_host host (.clk(clk), .rst(rst), .want_main(wm), .want_aux(wa), .bus_mode(bus_mode), .lag(lag),
    .main_en(me), .aux_en(ae));
  sps_top #(.CNT_W(16), .FILT_CY(FT)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby_supply_ok(stby),
    .main_enable_a(me[0]), .aux_enable_a(ae[0]), .rail5_current_sense_a(s5[0]), .rail3_current_sense_a(s3[0]),
    .overcurrent_a(oc[0]), .thermal_shutdown_a(th[0]), .undervoltage_lockout_a(uv[0]), .aux_overcurrent_a(ax[0]),
    .rail5_good_monitor_a(g5[0]), .rail3_good_monitor_a(g3[0]), .rail5_gate_a(g5o[0]), .rail3_gate_a(g3o[0]),
    .rail5_gate_reg_a(r5o[0]), .rail3_gate_reg_a(r3o[0]), .gate_pull_low_a(pl[0]), .gate_discharge_a(dis[0]),
    .standby_slot_out_a(axo[0]), .power_good5_a(p5[0]), .power_good3_a(p3[0]), .slot_fault_n_a_i(flv[0]),
    .slot_fault_n_a_o(), .slot_fault_n_a_oe(foe[0]),
    .main_enable_b(me[1]), .aux_enable_b(ae[1]), .rail5_current_sense_b(s5[1]), .rail3_current_sense_b(s3[1]),
    .overcurrent_b(oc[1]), .thermal_shutdown_b(th[1]), .undervoltage_lockout_b(uv[1]), .aux_overcurrent_b(ax[1]),
    .rail5_good_monitor_b(g5[1]), .rail3_good_monitor_b(g3[1]), .rail5_gate_b(g5o[1]), .rail3_gate_b(g3o[1]),
    .rail5_gate_reg_b(r5o[1]), .rail3_gate_reg_b(r3o[1]), .gate_pull_low_b(pl[1]), .gate_discharge_b(dis[1]),
    .standby_slot_out_b(axo[1]), .power_good5_b(p5[1]), .power_good3_b(p3[1]), .slot_fault_n_b_i(flv[1]),
    .slot_fault_n_b_o(), .slot_fault_n_b_oe(foe[1]), .int_n_i(int_lv), .int_n_o(), .int_n_oe(int_oe));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // One register port cycle.
  task automatic bus(input logic w, r, input logic [3:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] v, m);
    notes.push_back('{v, m});
    bus(1'b0, 1'b1, a, 32'h0);
    bus(1'b0, 1'b0, a, 32'h0);
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Reads answer a cycle late.
  always @(posedge clk)
  begin
    if (rd_seen)
    begin
      nt = notes.pop_front();
      chk(reg_rdata & nt.m, nt.v);
    end
    rd_seen <= reg_rd;
  end
  // A hang counts as a mismatch.
  initial
  begin
    cyc(5000);
    miscompares++;
    close_out();
  end
  initial
  begin
    {rst, stby, reg_wr, reg_rd, bus_mode, rd_seen} = 6'h30;
    {reg_addr, reg_wdata, lag, wm, wa, s5, s3, oc, th, uv, ax, g5, g3} = '0;
    compares = 0;
    miscompares = 0;
    lf_q = 17'h1329F;
    cyc(12);
    rst <= 1'b0;
    cyc(2);
    chk(32'(dis), 32'h3);
    rd(MK, 32'h0, 32'hF);
    rd(4'h2, 32'h0, 32'hFFFFFFFF);
    wr(4'h3, 32'hF);
    wr(SA, 32'hFFFF);
    bus(1'b1, 1'b0, MK, 32'hF);
    notes.push_back('{32'hF, 32'hF});
    bus(1'b0, 1'b1, MK, 32'h0);
    rd(SA, 32'h0, 32'h7F7F);
    for (int k = 0; k < 2; k++)
    begin
      lf_q = lfsr(lf_q);
      {g5[k], g3[k], lag} <= lf_q[4:0] & 5'h1B;
      wm[k] <= 1'b1;
      cyc(10);
      chk(32'({g5o[k], g3o[k], dis[k], axo[k]}), 32'hC);
      chk(32'({p5[k], p3[k]}), 32'({g5[k], g3[k]}));
      wa[k] <= 1'b1;
      cyc(10);
      chk(32'(axo[k]), 32'h1);
    end
    for (int k = 0; k < 6; k++)
    begin
      s = k % 2;
      {oc[s], th[s], uv[s]} <= 3'(4 >> (k / 2));
      cyc(2);
      chk(32'({pl[s], g5o[s], g3o[s], g5o[1-s]}), 32'h9);
      {oc[s], th[s], uv[s]} <= 3'h0;
      cyc(4);
      chk(32'(g5o[s]), 32'h0);
      wm[s] <= 1'b0;
      cyc(10);
      wm[s] <= 1'b1;
      cyc(10);
      chk(32'({g5o[s], pl[s]}), 32'h2);
    end
    wr(ST, 32'hF);
    cyc(1);
    chk(32'(int_oe), 32'h0);
    s5[0] <= 1'b1;
    cyc(2);
    chk(32'({r5o[0], g5o[0]}), 32'h2);
    cyc(FT - 4);
    s5[0] <= 1'b0;
    cyc(2);
    s5[0] <= 1'b1;
    n = 0;
    while (pl[0] !== 1'b1 && n < 3 * FT)
    begin
      cyc(1);
      n++;
    end
    s5[0] <= 1'b0;
    chk(32'(n >= FT - 1 && n <= FT + 2), 32'h1);
    cyc(3);
    chk(32'(int_oe), 32'h1);
    rd(ST, 32'h1, 32'hF);
    ax[0] <= 1'b1;
    cyc(3);
    ax[0] <= 1'b0;
    chk(32'(axo[0]), 32'h0);
    rd(ST, 32'h3, 32'hF);
    wm[0] <= 1'b0;
    cyc(10);
    chk(32'(foe[0]), 32'h1);
    wa[0] <= 1'b0;
    cyc(10);
    chk(32'(foe[0]), 32'h0);
    rd(SA, 32'h0, 32'h3);
    wr(ST, 32'h1);
    cyc(1);
    chk(32'(int_oe), 32'h1);
    wr(ST, 32'h2);
    cyc(1);
    chk(32'(int_oe), 32'h0);
    s3[1] <= 1'b1;
    cyc(2);
    chk(32'(r3o[1]), 32'h1);
    s3[1] <= 1'b0;
    wr(MK, 32'h0);
    ax[1] <= 1'b1;
    cyc(3);
    ax[1] <= 1'b0;
    chk(32'({axo[1], int_oe}), 32'h0);
    rd(ST, 32'h8, 32'hF);
    wr(MK, 32'h8);
    cyc(1);
    chk(32'(int_oe), 32'h1);
    wr(ST, 32'h8);
    cyc(1);
    chk(32'(int_oe), 32'h0);
    stby <= 1'b0;
    wa[1] <= 1'b0;
    cyc(10);
    wa[1] <= 1'b1;
    cyc(10);
    chk(32'(axo[1]), 32'h0);
    stby <= 1'b1;
    cyc(10);
    chk(32'(axo[1]), 32'h0);
    wa[1] <= 1'b0;
    cyc(10);
    wa[1] <= 1'b1;
    cyc(10);
    chk(32'(axo[1]), 32'h1);
    bus_mode <= 1'b1;
    cyc(10);
    chk(32'(g5o[1]), 32'h0);
    wr(CT, 32'h4);
    cyc(6);
    chk(32'({g5o[1], g3o[1]}), 32'h3);
    wr(CT, 32'h0);
    cyc(6);
    chk(32'(dis[1]), 32'h1);
    close_out();
  end
endmodule // sps_top_tb
